// ===== axis_mode_env_pkg.sv
/*
  constants, enumerations and carriers for the per-axis mode and
  environment configuration block.
  assumes a single 250 mhz clock and a byte-coded register command port.
*/
package axis_mode_env_pkg;

  // ==========================================================
  // register command codes
  localparam logic [7:0] CMD_WR_MODE_PRE = 8'h87;
  localparam logic [7:0] CMD_RD_MODE_PRE = 8'hc7;
  localparam logic [7:0] CMD_WR_MODE = 8'h97;
  localparam logic [7:0] CMD_RD_MODE = 8'hd7;
  localparam logic [7:0] CMD_WR_ENV1 = 8'h9c;
  localparam logic [7:0] CMD_RD_ENV1 = 8'hdc;
  localparam logic [7:0] CMD_DEFERRED_START = 8'h2a;
  localparam logic [7:0] CMD_STOP_PULSE = 8'h07;

  // ==========================================================
  // reset values and the writable mode mask
  localparam logic [31:0] MODE_RESET = 32'h0000_0000;
  localparam logic [31:0] ENV1_RESET = 32'h0000_0000;
  localparam logic [31:0] MODE_MASK = 32'h37ff_7f7f;

  // ==========================================================
  // mode register field positions
  localparam int MODE_MOTION_LSB = 0;
  localparam int MODE_MOTION_MSB = 6;
  localparam int MODE_SD_EN = 8;
  localparam int MODE_INP_EN = 9;
  localparam int MODE_SCURVE = 10;
  localparam int MODE_CNT_SRC = 11;
  localparam int MODE_DONE_TIMING = 12;
  localparam int MODE_SDP_MANUAL = 13;
  localparam int MODE_CNT_WAIT = 14;
  localparam int MODE_SEQ_LSB = 16;
  localparam int MODE_SEQ_MSB = 17;
  localparam int MODE_START_LSB = 18;
  localparam int MODE_START_MSB = 19;
  localparam int MODE_TRIG_LSB = 20;
  localparam int MODE_TRIG_MSB = 23;
  localparam int MODE_STOP_IN_EN = 24;
  localparam int MODE_STOP_OUT_EN = 25;
  localparam int MODE_TRI_ALLOW = 26;
  localparam int MODE_SLOW_IN_EN = 28;
  localparam int MODE_SLOW_OUT_EN = 29;

  // ==========================================================
  // environment register one field positions
  localparam int ENV_FMT_LSB = 0;
  localparam int ENV_FMT_MSB = 2;
  localparam int ENV_LIMIT_DECEL = 3;
  localparam int ENV_SD_STOP = 4;
  localparam int ENV_SD_LATCH = 5;
  localparam int ENV_SD_POL = 6;
  localparam int ENV_ORG_POL = 7;
  localparam int ENV_ALARM_DECEL = 8;
  localparam int ENV_INP_POL = 22;
  localparam int ENV_PCS_POL = 24;
  localparam int ENV_START_SEL = 30;

  // ==========================================================
  // motion mode codes and quadrature formats
  localparam logic [6:0] MOT_CONT_POS = 7'h00;
  localparam logic [6:0] MOT_CONT_NEG = 7'h08;
  localparam logic [6:0] MOT_CONT_PULSER = 7'h01;
  localparam logic [6:0] MOT_CONT_SWITCH = 7'h02;
  localparam logic [6:0] MOT_HOME_POS = 7'h10;
  localparam logic [6:0] MOT_HOME_NEG = 7'h18;
  localparam logic [6:0] MOT_INC = 7'h41;
  localparam logic [6:0] MOT_TIMER = 7'h47;
  localparam logic [6:0] MOT_INC_PULSER = 7'h51;
  localparam logic [6:0] MOT_INC_SWITCH = 7'h56;
  localparam logic [6:0] MOT_LIN_CONT = 7'h62;
  localparam logic [6:0] MOT_LIN_INC = 7'h63;
  localparam logic [2:0] FMT_QUAD_A = 3'h5;
  localparam logic [2:0] FMT_QUAD_B = 3'h6;

  // ==========================================================
  // start timing codes
  localparam logic [1:0] START_NOW = 2'h0;
  localparam logic [1:0] START_EXT = 2'h1;
  localparam logic [1:0] START_SYNC = 2'h2;
  localparam logic [1:0] START_AXES = 2'h3;

  // ==========================================================
  // timing
  localparam int CLK_MHZ = 250;
  localparam int STOP_PULSE_NS = 1000;
  localparam int STOP_PULSE_CYCLES = (STOP_PULSE_NS * CLK_MHZ) / 1000;

  typedef enum logic [3:0] {
    MK_NONE = 4'h0, MK_CONT_POS = 4'h1, MK_CONT_NEG = 4'h2,
    MK_CONT_PULSER = 4'h3, MK_CONT_SWITCH = 4'h4, MK_HOME_POS = 4'h5,
    MK_HOME_NEG = 4'h6, MK_INC = 4'h7, MK_TIMER = 4'h8,
    MK_INC_PULSER = 4'h9, MK_INC_SWITCH = 4'ha, MK_LIN_CONT = 4'hb,
    MK_LIN_INC = 4'hc
  } motionKind_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_WAIT = 2'b01, ST_RUN = 2'b10, ST_DONE = 2'b11
  } seqState_e;

  // motion engine report into this block
  typedef struct packed {
    logic decelerating;
    logic atLowSpeed;
    logic emergencyStop;
    logic lastPulseOnEnd;
    logic lastPulseCycleEnd;
    logic directionNeg;
    logic internalSync;
    logic [3:0] axisStopped;
  } engineStatus_s;

  // decoded controls out to the motion engine
  typedef struct packed {
    motionKind_e kind;
    logic [2:0] pulseFormat;
    logic quadOutput;
    logic sCurve;
    logic countEncoder;
    logic autoSlowdown;
    logic allowTriangle;
    logic holdTargetCount;
    logic slowDecel;
    logic slowStop;
    logic limitStopNow;
    logic limitStopDecel;
    logic alarmDecel;
    logic sharedStopReq;
    logic sharedSlowToLow;
    logic originActive;
    logic [1:0] sequenceNo;
  } engineCtrl_s;

  // pin levels and flags seen by software
  typedef struct packed {
    logic slowdownLevel;
    logic slowdownLatched;
    logic inPositionLevel;
    logic countStartLevel;
    logic sharedStopLevel;
    logic sharedSlowLevel;
    logic busy;
  } pinStatus_s;

endpackage

// ===== axis_mode_env_config.sv
/*
  operation mode and environment one registers of one axis, the start
  sequencer and pin role decoding.
  assumes a motion engine on the same clock and asynchronous pins.
*/
// Summary of operation
// - motion field codes 00h,08h,01h,02h select continuous motion kinds.
// - codes 10h and 18h select home seeking, positive or negative.
// - 41h incremental, 47h timer, 51h pulser incremental, 56h switch incremental.
// - 62h continuous and 63h incremental linear interpolation.
// - slow-down enable off makes input plain status, on makes it decelerate.
// - in-position enable delays completion until positioning-complete input active.
// - count-select bit picks encoder counting instead of command pulses.
// - completion at last pulse full cycle, or at its on width.
// - slow-down point automatic when clear, manual when set; host keeps limits.
// - count-start input role from its bit and the start-input select.
// - start timing: at once, external start, internal sync, or axes stopped.
// - four trigger bits pick stop-start axes; unimplemented axes ignored.
// - shared stop input enabled stops the axis, otherwise plain status.
// - shared stop line one-shot low on emergency stop when its enable bit is set, else on command 07h.
// - triangle bit clear suppresses triangular profiles, set allows them.
// - shared slow input enabled drops target speed to low start speed.
// - shared slow line driven low while decelerating or at low speed.
// - slow-down action bit picks decelerate only or decelerate to stop.
// - slow-down latch catches short pulses; cleared at start while the input is inactive, or by write.
// - slow-down and origin polarity bits, alarm stop kind bit.
module axis_mode_env_config #(
  parameter int AXES = 4
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // register command port
  input wire logic cmdValid,
  input wire logic [7:0] cmdCode,
  input wire logic [31:0] cmdData,
  output logic [31:0] rdData,
  // host start request
  input wire logic startRequest,
  // motion engine
  input axis_mode_env_pkg::engineStatus_s engStatus,
  output axis_mode_env_pkg::engineCtrl_s engCtrl,
  output logic runStart,
  output logic opComplete,
  // asynchronous pins
  input wire logic slowdown_input,
  input wire logic positioning_complete_input,
  input wire logic count_start_input,
  input wire logic shared_start_line,
  input wire logic sharedStopIn,
  input wire logic sharedSlowIn,
  input wire logic originIn,
  input wire logic endLimitPos,
  input wire logic endLimitNeg,
  // open drain shared lines
  output logic sharedStopOut,
  output logic sharedStopOe_n,
  output logic sharedSlowOut,
  output logic sharedSlowOe_n,
  // status
  output axis_mode_env_pkg::pinStatus_s pinStatus
);

  // ==========================================================
  // reset release and pin synchronisers
  logic [1:0] rstSync_ff;
  logic rstInt_n;
  logic [8:0] pinRaw;
  logic [8:0] pinMeta_ff;
  logic [8:0] pinSync_ff;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) rstSync_ff <= 2'h0;
    else rstSync_ff <= {rstSync_ff[0], 1'b1};
  end
  assign rstInt_n = rstSync_ff[1];

  assign pinRaw = {endLimitNeg, endLimitPos, originIn, sharedSlowIn,
                   sharedStopIn, shared_start_line, count_start_input,
                   positioning_complete_input, slowdown_input};

  genvar gi;
  generate
    for (gi = 0; gi < 9; gi++) begin : g_sync
      always_ff @(posedge mclk or negedge rstInt_n) begin
        if (!rstInt_n) begin
          pinMeta_ff[gi] <= 1'b1;
          pinSync_ff[gi] <= 1'b1;
        end else begin
          pinMeta_ff[gi] <= pinRaw[gi];
          pinSync_ff[gi] <= pinMeta_ff[gi];
        end
      end
    end
  endgenerate

  // ==========================================================
  // registers and command decode
  logic [31:0] modePre_ff;
  logic [31:0] mode_ff;
  logic [31:0] env_ff;
  logic [31:0] rdData_ff;
  logic wrModePre;
  logic wrMode;
  logic wrEnv;
  logic deferredCmd;
  logic stopPulseCmd;
  logic goNow;
  logic [31:0] nxt_rdData;

  assign wrModePre = cmdValid && cmdCode == axis_mode_env_pkg::CMD_WR_MODE_PRE;
  assign wrMode = cmdValid && cmdCode == axis_mode_env_pkg::CMD_WR_MODE;
  assign wrEnv = cmdValid && cmdCode == axis_mode_env_pkg::CMD_WR_ENV1;
  assign deferredCmd = cmdValid &&
                       cmdCode == axis_mode_env_pkg::CMD_DEFERRED_START;
  assign stopPulseCmd = cmdValid &&
                        cmdCode == axis_mode_env_pkg::CMD_STOP_PULSE;

  always_comb begin
    nxt_rdData = rdData_ff;
    if (cmdValid) begin
      unique case (cmdCode)
        axis_mode_env_pkg::CMD_RD_MODE_PRE: nxt_rdData = modePre_ff;
        axis_mode_env_pkg::CMD_RD_MODE: nxt_rdData = mode_ff;
        axis_mode_env_pkg::CMD_RD_ENV1: nxt_rdData = env_ff;
        default: nxt_rdData = rdData_ff;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rstInt_n) begin
    if (!rstInt_n) begin
      modePre_ff <= axis_mode_env_pkg::MODE_RESET;
      mode_ff <= axis_mode_env_pkg::MODE_RESET;
      env_ff <= axis_mode_env_pkg::ENV1_RESET;
      rdData_ff <= 32'h0000_0000;
    end else begin
      if (wrModePre) modePre_ff <= cmdData & axis_mode_env_pkg::MODE_MASK;
      if (goNow) mode_ff <= modePre_ff;
      else if (wrMode) mode_ff <= cmdData & axis_mode_env_pkg::MODE_MASK;
      if (wrEnv) env_ff <= cmdData;
      rdData_ff <= nxt_rdData;
    end
  end
  assign rdData = rdData_ff;

  // ==========================================================
  // active pin levels
  logic sdActive;
  logic inpActive;
  logic pcsActive;
  logic startLow;
  logic stopLow;
  logic slowLow;
  logic startSel;

  assign sdActive = pinSync_ff[0] ~^ env_ff[axis_mode_env_pkg::ENV_SD_POL];
  assign inpActive = pinSync_ff[1] ~^ env_ff[axis_mode_env_pkg::ENV_INP_POL];
  assign pcsActive = pinSync_ff[2] ~^ env_ff[axis_mode_env_pkg::ENV_PCS_POL];
  assign startLow = !pinSync_ff[3];
  assign stopLow = !pinSync_ff[4];
  assign slowLow = !pinSync_ff[5];
  assign startSel = env_ff[axis_mode_env_pkg::ENV_START_SEL];

  // ==========================================================
  // start and completion sequencer
  axis_mode_env_pkg::seqState_e state_ff;
  axis_mode_env_pkg::seqState_e nxt_state;
  logic [1:0] startTiming;
  logic [AXES-1:0] trigMask;
  logic extStart;
  logic axesStopped;
  logic startMet;
  logic lastPulseDone;
  logic pcsSeen_ff;

  assign startTiming = modePre_ff[axis_mode_env_pkg::MODE_START_MSB:
                                  axis_mode_env_pkg::MODE_START_LSB];
  assign trigMask = modePre_ff[axis_mode_env_pkg::MODE_TRIG_LSB +: AXES];
  assign extStart = deferredCmd || (startSel ? pcsActive : startLow);
  assign axesStopped = (trigMask & ~engStatus.axisStopped[AXES-1:0]) == '0;

  always_comb begin
    unique case (startTiming)
      axis_mode_env_pkg::START_NOW: startMet = 1'b1;
      axis_mode_env_pkg::START_EXT: startMet = extStart;
      axis_mode_env_pkg::START_SYNC: startMet = engStatus.internalSync;
      axis_mode_env_pkg::START_AXES: startMet = axesStopped;
    endcase
  end

  assign goNow = state_ff == axis_mode_env_pkg::ST_WAIT && startMet;
  assign lastPulseDone = mode_ff[axis_mode_env_pkg::MODE_DONE_TIMING] ?
                         engStatus.lastPulseOnEnd :
                         engStatus.lastPulseCycleEnd;

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      axis_mode_env_pkg::ST_IDLE:
        if (startRequest) nxt_state = axis_mode_env_pkg::ST_WAIT;
      axis_mode_env_pkg::ST_WAIT:
        if (startMet) nxt_state = axis_mode_env_pkg::ST_RUN;
      axis_mode_env_pkg::ST_RUN:
        if (lastPulseDone) nxt_state = axis_mode_env_pkg::ST_DONE;
      axis_mode_env_pkg::ST_DONE:
        if (!mode_ff[axis_mode_env_pkg::MODE_INP_EN] || inpActive) begin
          nxt_state = axis_mode_env_pkg::ST_IDLE;
        end
    endcase
  end

  always_ff @(posedge mclk or negedge rstInt_n) begin
    if (!rstInt_n) state_ff <= axis_mode_env_pkg::ST_IDLE;
    else state_ff <= nxt_state;
  end

  assign runStart = goNow;
  assign opComplete = state_ff == axis_mode_env_pkg::ST_DONE &&
                      nxt_state == axis_mode_env_pkg::ST_IDLE;

  // count-start wait: continuous until the input arrives
  always_ff @(posedge mclk or negedge rstInt_n) begin
    if (!rstInt_n) pcsSeen_ff <= 1'b0;
    else if (goNow) pcsSeen_ff <= 1'b0;
    else if (pcsActive) pcsSeen_ff <= 1'b1;
  end

  // ==========================================================
  // slow-down latch
  logic sdLatch_ff;
  logic sdLatchClr;

  assign sdLatchClr = (goNow && !sdActive) ||
                      (wrEnv && !cmdData[axis_mode_env_pkg::ENV_SD_LATCH]);
  always_ff @(posedge mclk or negedge rstInt_n) begin
    if (!rstInt_n) sdLatch_ff <= 1'b0;
    else if (env_ff[axis_mode_env_pkg::ENV_SD_LATCH] && sdActive)
      sdLatch_ff <= 1'b1;
    else if (sdLatchClr) sdLatch_ff <= 1'b0;
  end

  // ==========================================================
  // shared stop one-shot
  logic [$clog2(axis_mode_env_pkg::STOP_PULSE_CYCLES+1)-1:0] stopCnt_ff;
  logic stopFire;

  assign stopFire = mode_ff[axis_mode_env_pkg::MODE_STOP_OUT_EN] ?
                    engStatus.emergencyStop : stopPulseCmd;
  always_ff @(posedge mclk or negedge rstInt_n) begin
    if (!rstInt_n) stopCnt_ff <= '0;
    else if (stopFire)
      stopCnt_ff <= $bits(stopCnt_ff)'(axis_mode_env_pkg::STOP_PULSE_CYCLES);
    else if (stopCnt_ff != '0) stopCnt_ff <= stopCnt_ff - 1'b1;
  end
  assign sharedStopOut = 1'b0;
  assign sharedStopOe_n = stopCnt_ff == '0;

  // shared slow line
  logic slowDrive_ff;
  always_ff @(posedge mclk or negedge rstInt_n) begin
    if (!rstInt_n) slowDrive_ff <= 1'b0;
    else slowDrive_ff <= mode_ff[axis_mode_env_pkg::MODE_SLOW_OUT_EN] &&
                         (engStatus.decelerating || engStatus.atLowSpeed);
  end
  assign sharedSlowOut = 1'b0;
  assign sharedSlowOe_n = !slowDrive_ff;

  // ==========================================================
  // motion kind decode
  logic [6:0] motionField;
  axis_mode_env_pkg::motionKind_e kind;

  assign motionField = mode_ff[axis_mode_env_pkg::MODE_MOTION_MSB:
                               axis_mode_env_pkg::MODE_MOTION_LSB];
  always_comb begin
    unique case (motionField)
      axis_mode_env_pkg::MOT_CONT_POS: kind = axis_mode_env_pkg::MK_CONT_POS;
      axis_mode_env_pkg::MOT_CONT_NEG: kind = axis_mode_env_pkg::MK_CONT_NEG;
      axis_mode_env_pkg::MOT_CONT_PULSER:
        kind = axis_mode_env_pkg::MK_CONT_PULSER;
      axis_mode_env_pkg::MOT_CONT_SWITCH:
        kind = axis_mode_env_pkg::MK_CONT_SWITCH;
      axis_mode_env_pkg::MOT_HOME_POS: kind = axis_mode_env_pkg::MK_HOME_POS;
      axis_mode_env_pkg::MOT_HOME_NEG: kind = axis_mode_env_pkg::MK_HOME_NEG;
      axis_mode_env_pkg::MOT_INC: kind = axis_mode_env_pkg::MK_INC;
      axis_mode_env_pkg::MOT_TIMER: kind = axis_mode_env_pkg::MK_TIMER;
      axis_mode_env_pkg::MOT_INC_PULSER:
        kind = axis_mode_env_pkg::MK_INC_PULSER;
      axis_mode_env_pkg::MOT_INC_SWITCH:
        kind = axis_mode_env_pkg::MK_INC_SWITCH;
      axis_mode_env_pkg::MOT_LIN_CONT: kind = axis_mode_env_pkg::MK_LIN_CONT;
      axis_mode_env_pkg::MOT_LIN_INC: kind = axis_mode_env_pkg::MK_LIN_INC;
      default: kind = axis_mode_env_pkg::MK_NONE;
    endcase
  end

  // ==========================================================
  // controls to the engine
  logic sdEn;
  logic limitHit;
  logic [2:0] fmt;

  assign sdEn = mode_ff[axis_mode_env_pkg::MODE_SD_EN] && sdActive;
  assign limitHit = engStatus.directionNeg ? !pinSync_ff[8] : !pinSync_ff[7];
  assign fmt = env_ff[axis_mode_env_pkg::ENV_FMT_MSB:
                      axis_mode_env_pkg::ENV_FMT_LSB];

  assign engCtrl.kind = kind;
  assign engCtrl.pulseFormat = fmt;
  assign engCtrl.quadOutput = fmt == axis_mode_env_pkg::FMT_QUAD_A ||
                              fmt == axis_mode_env_pkg::FMT_QUAD_B;
  assign engCtrl.sCurve = mode_ff[axis_mode_env_pkg::MODE_SCURVE];
  assign engCtrl.countEncoder = mode_ff[axis_mode_env_pkg::MODE_CNT_SRC];
  assign engCtrl.autoSlowdown =
    !mode_ff[axis_mode_env_pkg::MODE_SDP_MANUAL];
  assign engCtrl.allowTriangle = mode_ff[axis_mode_env_pkg::MODE_TRI_ALLOW];
  assign engCtrl.holdTargetCount = mode_ff[axis_mode_env_pkg::MODE_CNT_WAIT] &&
                                   !startSel && !pcsSeen_ff;
  assign engCtrl.slowDecel = sdEn &&
                             !env_ff[axis_mode_env_pkg::ENV_SD_STOP];
  assign engCtrl.slowStop = sdEn && env_ff[axis_mode_env_pkg::ENV_SD_STOP];
  assign engCtrl.limitStopNow = limitHit &&
                                !env_ff[axis_mode_env_pkg::ENV_LIMIT_DECEL];
  assign engCtrl.limitStopDecel = limitHit &&
                                  env_ff[axis_mode_env_pkg::ENV_LIMIT_DECEL];
  assign engCtrl.alarmDecel = env_ff[axis_mode_env_pkg::ENV_ALARM_DECEL];
  assign engCtrl.sharedStopReq = stopLow &&
                                 mode_ff[axis_mode_env_pkg::MODE_STOP_IN_EN];
  assign engCtrl.sharedSlowToLow = slowLow &&
                                   mode_ff[axis_mode_env_pkg::MODE_SLOW_IN_EN];
  assign engCtrl.originActive =
    pinSync_ff[6] ~^ env_ff[axis_mode_env_pkg::ENV_ORG_POL];
  assign engCtrl.sequenceNo = mode_ff[axis_mode_env_pkg::MODE_SEQ_MSB:
                                      axis_mode_env_pkg::MODE_SEQ_LSB];

  // ==========================================================
  // status
  assign pinStatus.slowdownLevel = sdActive;
  assign pinStatus.slowdownLatched = sdLatch_ff;
  assign pinStatus.inPositionLevel = inpActive;
  assign pinStatus.countStartLevel = pcsActive;
  assign pinStatus.sharedStopLevel = stopLow;
  assign pinStatus.sharedSlowLevel = slowLow;
  assign pinStatus.busy = state_ff != axis_mode_env_pkg::ST_IDLE;

endmodule

// ===== axis_mode_env_assertions.sv
/*
  port checker for the axis mode and environment block.
  assumes a bind from the test top and one clock domain.
*/
module axis_mode_env_assertions #(
  parameter int AXES = 4
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // sequencing
  input wire logic startRequest,
  input wire logic runStart,
  input wire logic opComplete,
  input axis_mode_env_pkg::engineStatus_s engStatus,
  input axis_mode_env_pkg::engineCtrl_s engCtrl,
  input axis_mode_env_pkg::pinStatus_s pinStatus,
  // shared lines
  input wire logic sharedStopOe_n,
  input wire logic sharedSlowOe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========
  // stop line low time
  logic [15:0] lowCnt_ff;
  wire logic [15:0] nxt_lowCnt = sharedStopOe_n ? 16'h0 : lowCnt_ff + 16'h1;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) lowCnt_ff <= 16'h0;
    else lowCnt_ff <= nxt_lowCnt;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // ==========
  // properties
  sequence seqTake;
    startRequest && !pinStatus.busy;
  endsequence
  AST_TAKE_START: assert property (
    seqTake |=> pinStatus.busy) else $error("start not taken");
  AST_RUN_BUSY: assert property (
    runStart |-> pinStatus.busy) else $error("run start while idle");
  AST_RUN_ONCE: assert property (
    runStart |=> !runStart) else $error("run start too long");
  AST_DONE_IDLE: assert property (
    opComplete |=> !pinStatus.busy && !opComplete)
    else $error("no idle after done");
  AST_SLOW_CAUSE: assert property (
    !sharedSlowOe_n |->
    $past(engStatus.decelerating || engStatus.atLowSpeed))
    else $error("slow line low without cause");
  AST_STOP_LEN: assert property (
    $rose(sharedStopOe_n) |->
    lowCnt_ff >= axis_mode_env_pkg::STOP_PULSE_CYCLES)
    else $error("stop pulse short");
  AST_STOP_STAY: assert property (
    $fell(sharedStopOe_n) |=> !sharedStopOe_n [*8])
    else $error("stop pulse broken");
  AST_QUAD: assert property (
    engCtrl.quadOutput ==
    (engCtrl.pulseFormat == axis_mode_env_pkg::FMT_QUAD_A ||
    engCtrl.pulseFormat == axis_mode_env_pkg::FMT_QUAD_B))
    else $error("quad decode wrong");
  AST_LIMIT_ONE: assert property (
    !(engCtrl.limitStopNow && engCtrl.limitStopDecel))
    else $error("two limit stop kinds");
endmodule

// ===== host_cmd_model.sv
/*
  host model driving the register command port.
  assumes commands are taken on the rising edge.
*/
module host_cmd_model (
  // clock
  input wire logic mclk,
  // command port
  output logic cmdValid,
  output logic [7:0] cmdCode,
  output logic [31:0] cmdData
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cmdValid = 1'b0;
    cmdCode = 8'h00;
    cmdData = 32'h0;
  end
  // one word a command, held over one edge
  task automatic send(input logic [7:0] code, input logic [31:0] data);
    @(negedge mclk);
    cmdValid = 1'b1;
    cmdCode = code;
    cmdData = data;
    @(negedge mclk);
    cmdValid = 1'b0;
    cmdData = ~data;
  endtask
endmodule

// ===== axis_mode_env_config_test.sv
/*
  self-checking bench for the axis mode block.
  assumes the host model and the port checker.
*/
module axis_mode_env_config_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, rst_n, startRequest, runStart, opComplete, cmdValid;
  logic [7:0] cmdCode;
  logic [31:0] cmdData, rdData;
  axis_mode_env_pkg::engineStatus_s eng;
  axis_mode_env_pkg::engineCtrl_s ctl;
  axis_mode_env_pkg::pinStatus_s pst;
  logic sdIn, inpIn, pcsIn, staIn, stpIn, slwIn, orgIn, limP, limN;
  logic stopOut, stopOe_n, slowOut, slowOe_n;
  logic [6:0] codes [12] = '{7'h00, 7'h08, 7'h01, 7'h02, 7'h10, 7'h18,
    7'h41, 7'h47, 7'h51, 7'h56, 7'h62, 7'h63};
  int n_fail = 0, checked = 0, cyc = 0, k, i;
  host_cmd_model host_u (.mclk(mclk), .cmdValid(cmdValid),
    .cmdCode(cmdCode), .cmdData(cmdData));
  axis_mode_env_config dut_u (.mclk(mclk), .rst_n(rst_n),
    .cmdValid(cmdValid), .cmdCode(cmdCode), .cmdData(cmdData),
    .rdData(rdData), .startRequest(startRequest), .engStatus(eng),
    .engCtrl(ctl), .runStart(runStart), .opComplete(opComplete),
    .slowdown_input(sdIn), .positioning_complete_input(inpIn),
    .count_start_input(pcsIn), .shared_start_line(staIn),
    .sharedStopIn(stpIn), .sharedSlowIn(slwIn), .originIn(orgIn),
    .endLimitPos(limP), .endLimitNeg(limN), .sharedStopOut(stopOut),
    .sharedStopOe_n(stopOe_n), .sharedSlowOut(slowOut),
    .sharedSlowOe_n(slowOe_n), .pinStatus(pst));
  // ==========
  // helpers
  task automatic complete_run();
    if (n_fail == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, exp, input string msg);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask
  task automatic rd(input logic [7:0] c, input logic [31:0] e, string m);
    host_u.send(c, 32'h0);
    chk(rdData, e, m);
  endtask
  task automatic start_op(input logic [31:0] pre);
    host_u.send(axis_mode_env_pkg::CMD_WR_MODE_PRE, pre);
    @(negedge mclk);
    startRequest = 1'b1;
    @(negedge mclk);
    startRequest = 1'b0;
    for (k = 0; k < 20 && runStart !== 1'b1; k++) @(negedge mclk);
    chk(runStart, 1'b1, "no run start");
  endtask
  task automatic finish_op(input logic onEnd, input logic done);
    @(negedge mclk);
    eng.lastPulseOnEnd = onEnd;
    eng.lastPulseCycleEnd = !onEnd;
    @(negedge mclk);
    eng.lastPulseOnEnd = 1'b0;
    eng.lastPulseCycleEnd = 1'b0;
    chk(opComplete, done, "completion");
  endtask
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      $display("unexpected at %0t: timeout", $time);
      complete_run();
    end
  end
  // ==========
  // tests
  initial begin
    rst_n = 1'b0;
    startRequest = 1'b0;
    eng = '0;
    {sdIn, inpIn, pcsIn, staIn, stpIn, slwIn, orgIn, limP, limN} = '1;
    repeat (3) @(negedge mclk);
    rst_n = 1'b1;
    repeat (3) @(negedge mclk);
    rd(axis_mode_env_pkg::CMD_RD_MODE, 32'h0, "mode reset");
    host_u.send(axis_mode_env_pkg::CMD_WR_MODE, 32'hffff_ffff);
    rd(axis_mode_env_pkg::CMD_RD_MODE, 32'h37ff_7f7f, "mode bits");
    host_u.send(axis_mode_env_pkg::CMD_WR_ENV1, 32'hffff_ffff);
    rd(axis_mode_env_pkg::CMD_RD_ENV1, 32'hffff_ffff, "env bits");
    chk(ctl.countEncoder, 1'b1, "count source");
    chk(ctl.allowTriangle, 1'b1, "triangle");
    chk(ctl.autoSlowdown, 1'b0, "slow point");
    chk(ctl.alarmDecel, 1'b1, "alarm kind");
    chk(ctl.slowStop, 1'b1, "slow stop");
    chk(pst.slowdownLevel, 1'b1, "slow level");
    chk(pst.slowdownLatched, 1'b1, "slow latch");
    chk(ctl.sharedStopReq, 1'b0, "shared stop idle");
    for (i = 0; i < 8; i++) begin
      host_u.send(axis_mode_env_pkg::CMD_WR_ENV1, 32'(i));
      chk(ctl.quadOutput, i == 5 || i == 6, "format");
    end
    for (i = 0; i < 12; i++) begin
      start_op({25'h0, codes[i]});
      rd(axis_mode_env_pkg::CMD_RD_MODE, {25'h0, codes[i]}, "xfer");
      chk(ctl.kind, 32'(i + 1), "motion kind");
      finish_op(1'b0, 1'b1);
    end
    start_op(32'h0000_1041);
    finish_op(1'b0, 1'b0);
    finish_op(1'b1, 1'b1);
    start_op(32'h0000_0241);
    finish_op(1'b0, 1'b0);
    inpIn = 1'b0;
    for (k = 0; k < 8 && opComplete !== 1'b1; k++) @(negedge mclk);
    chk(opComplete, 1'b1, "in position");
    inpIn = 1'b1;
    host_u.send(axis_mode_env_pkg::CMD_WR_MODE_PRE, 32'h0004_0041);
    @(negedge mclk);
    startRequest = 1'b1;
    @(negedge mclk);
    startRequest = 1'b0;
    repeat (4) @(negedge mclk);
    chk(runStart, 1'b0, "early start");
    staIn = 1'b0;
    for (k = 0; k < 8 && runStart !== 1'b1; k++) @(negedge mclk);
    chk(runStart, 1'b1, "shared start");
    finish_op(1'b0, 1'b1);
    staIn = 1'b1;
    host_u.send(axis_mode_env_pkg::CMD_STOP_PULSE, 32'h0);
    for (k = 0; k < 400 && stopOe_n !== 1'b1; k++) @(negedge mclk);
    chk(k, axis_mode_env_pkg::STOP_PULSE_CYCLES, "stop width");
    chk(stopOut, 1'b0, "stop level");
    host_u.send(axis_mode_env_pkg::CMD_WR_MODE, 32'h2000_0000);
    eng.decelerating = 1'b1;
    @(negedge mclk);
    chk(slowOe_n, 1'b0, "slow decel");
    eng.decelerating = 1'b0;
    eng.atLowSpeed = 1'b1;
    @(negedge mclk);
    chk(slowOe_n, 1'b0, "slow low speed");
    host_u.send(axis_mode_env_pkg::CMD_WR_MODE, 32'h0);
    @(negedge mclk);
    chk(slowOe_n, 1'b1, "slow disabled");
    eng.atLowSpeed = 1'b0;
    complete_run();
  end
endmodule
bind axis_mode_env_config axis_mode_env_assertions #(.AXES(AXES)) chk_u (
  .mclk(mclk), .rst_n(rst_n), .startRequest(startRequest),
  .runStart(runStart), .opComplete(opComplete), .engStatus(engStatus),
  .engCtrl(engCtrl), .pinStatus(pinStatus),
  .sharedStopOe_n(sharedStopOe_n), .sharedSlowOe_n(sharedSlowOe_n));
